// ===== design/dtfwx_top.sv
/*
 * Dead-time, pattern and fault extension for four timer compare channels.
 * Assumes timer waveforms, update strobe, events and software strobes are
 * synchronous to sys_clk; register writes arrive as one-cycle strobes.
 */
// What this block does
// - Each channel waveform splits into true low side and inverted high side.
// - Dead-time enable takes the pin pair; override bits gate the pins.
// - Pins of unused pairs stay with the second timer when C is off.
// - Dead time holds both sides low.
// - Four generators share double-buffered low and high dead-time values.
// - Eight-bit counter decrements each clock, stopping at zero.
// - Non-zero counter forces both outputs off.
// - Rising edge loads low value, falling edge loads high value.
// - Pattern mode bypasses dead time; the low dead-time registers hold the pattern.
// - Pattern mode drives channel A waveform on every overridden pin.
// - Buffered values move to active only at timer update.
// - Selected event channels ORed together raise a fault unless the action is none.
// - Clear-override action clears the whole override register.
// - Direction-clear action clears directions of enabled-pair pins (low buffer pins in pattern mode), tri-stating them.
// - Fault sets the detect flag and pulses the timer error flag.
// - Fault action lands within two clocks of the event.
// - Latched mode waits for clear condition and flag clear, then update.
// - Cycle mode waits only for clear condition, then update.
// - After clear-override fault, override bits reload at update.
// - After direction-clear fault, direction bits are restored.
// - Lock bit blocks writes to control, override and event mask.
// - Debugger break counts as fault unless disabled.
// - Action codes: 00 none, 01 clear override, 11 clear direction.
// - Flag clears on any flag-clear write strobe; no data bit is checked.
module dtfwx_top (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] timer_waveform,
	input wire logic timer_update,
	input wire logic lock_update,
	input wire logic [7:0] port_value,
	input wire logic [7:0] port_direction_in,
	input wire logic [7:0] fault_events,
	input wire logic debug_break,
	input wire logic ext_lock,
	input wire logic ctrl_write,
	input wire logic [5:0] ctrl_wdata,
	input wire logic mask_write,
	input wire dtfwx_pkg::dtfwx_byte_t mask_wdata,
	input wire logic fdctrl_write,
	input wire logic [4:0] fdctrl_wdata,
	input wire logic flag_clear_write,
	input wire logic oven_write,
	input wire dtfwx_pkg::dtfwx_byte_t oven_wdata,
	input wire logic dtls_buf_write,
	input wire logic high_side_dead_time_buf_write,
	input wire dtfwx_pkg::dtfwx_byte_t dt_buf_wdata,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_taken,
	output dtfwx_pkg::dtfwx_byte_t override_enable_register,
	output logic fault_detect_flag,
	output logic timer_error_pulse,
	output logic low_buf_valid,
	output logic high_buf_valid
);
	import dtfwx_pkg::*;
`include "dtfwx_defs.svh"

	// ****************************************
	// Control state
	// ****************************************
	logic [5:0] ctrl_reg, ctrl_next;
	dtfwx_byte_t mask_reg, mask_next, oven_reg, oven_next;
	logic [4:0] fdc_reg, fdc_next;
	dtfwx_byte_t dtls_reg, dtls_next, high_side_dead_time_reg, high_side_dead_time_next;
	dtfwx_byte_t lsbuf_reg, lsbuf_next, hsbuf_reg, hsbuf_next;
	logic lsv_reg, lsv_next, hsv_reg, hsv_next;
	dtfwx_byte_t dir_reg, dir_next;
	logic [7:0] out_reg, out_next;
	logic err_reg, err_next;

	logic [3:0] dt_en;
	logic pattern_mode, common_wave, upd, feature_on;
	logic [7:0] pair_mask, ls_hs;
	logic f_flag, f_state, f_enter, f_leave;
	dtfwx_act_t act;

	// Expand four channel enables to their pin pairs
	function automatic logic [7:0] dtfwx_pairs(input logic [3:0] en);
		logic [7:0] m;
		m = `DTFWX_BYTE_RST;
		for (int i = 0; i < `DTFWX_NCH; i++) begin
			m[2*i] = en[i];
			m[2*i+1] = en[i];
		end
		return m;
	endfunction : dtfwx_pairs

	assign dt_en = ctrl_reg[3:0];
	assign common_wave = ctrl_reg[4];
	assign pattern_mode = ctrl_reg[5];
	assign act = fdc_reg[1:0];
	assign upd = timer_update && !lock_update;
	assign pair_mask = dtfwx_pairs(dt_en);
	assign feature_on = pattern_mode || (|dt_en);

	// ****************************************
	// Dead-time generators
	// ****************************************
	for (genvar g = 0; g < `DTFWX_NCH; g++) begin : g_dt
		dtfwx_dtgen u_gen (
			.sys_clk(sys_clk),
			.rstn(rstn),
			.wave(common_wave ? timer_waveform[0] : timer_waveform[g]),
			.dt_low(dtls_reg),
			.dt_high(high_side_dead_time_reg),
			.low_side_output(ls_hs[2*g]),
			.high_side_output(ls_hs[2*g+1])
		);
	end

	dtfwx_fault u_fault (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.fault_events(fault_events),
		.event_mask(mask_reg),
		.debug_break(debug_break),
		.break_fault_disable(fdc_reg[4]),
		.fault_action_field(act),
		.cycle_mode(fdc_reg[2]),
		.flag_clear_write(flag_clear_write),
		.update(upd),
		.fault_detect_flag(f_flag),
		.fault_state(f_state),
		.fault_enter(f_enter),
		.fault_leave(f_leave)
	);

	// ****************************************
	// Register writes, buffers and fault actions
	// ****************************************
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		oven_next = oven_reg;
		fdc_next = fdc_reg;
		dtls_next = dtls_reg;
		high_side_dead_time_next = high_side_dead_time_reg;
		lsbuf_next = lsbuf_reg;
		hsbuf_next = hsbuf_reg;
		lsv_next = lsv_reg;
		hsv_next = hsv_reg;
		dir_next = port_direction_in;
		err_next = f_enter;
		if (!ext_lock) begin
			if (ctrl_write) begin
				ctrl_next = ctrl_wdata;
			end
			if (mask_write) begin
				mask_next = mask_wdata;
			end
			if (oven_write && !f_flag) begin
				oven_next = oven_wdata;
			end
		end
		if (fdctrl_write) begin
			fdc_next = fdctrl_wdata;
		end
		if (dtls_buf_write) begin
			lsbuf_next = dt_buf_wdata;
			lsv_next = 1'b1;
		end
		if (high_side_dead_time_buf_write) begin
			hsbuf_next = dt_buf_wdata;
			hsv_next = 1'b1;
		end
		if (upd) begin
			if (lsv_reg) begin
				dtls_next = lsbuf_reg;
				lsv_next = dtls_buf_write;
			end
			if (hsv_reg) begin
				high_side_dead_time_next = hsbuf_reg;
				hsv_next = high_side_dead_time_buf_write;
			end
		end
		// Fault action within two clocks of the event
		if (f_state || f_enter) begin
			if (act == `DTFWX_ACT_CLROE) begin
				oven_next = `DTFWX_BYTE_RST;
			end
			if (act == `DTFWX_ACT_CLRDIR) begin
				dir_next = port_direction_in & ~(pattern_mode ? lsbuf_reg : pair_mask);
			end
		end
		if (f_leave) begin
			if (act == `DTFWX_ACT_CLROE) begin
				oven_next = pattern_mode ? lsbuf_reg : pair_mask;
			end
			if (act == `DTFWX_ACT_CLRDIR) begin
				dir_next = port_direction_in | (pattern_mode ? lsbuf_reg : pair_mask);
			end
		end
	end

	// ****************************************
	// Pin multiplexer
	// ****************************************
	always_comb begin
		out_next = port_value;
		for (int p = 0; p < `DTFWX_NPIN; p++) begin
			if (pattern_mode) begin
				// Dead time bypassed; pattern from the active low register
				if (oven_reg[p]) begin
					out_next[p] = timer_waveform[0];
				end else begin
					out_next[p] = dtls_reg[p];
				end
			end else if (pair_mask[p] && oven_reg[p]) begin
				out_next[p] = ls_hs[p];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= `DTFWX_CTRL_RST;
			mask_reg <= `DTFWX_BYTE_RST;
			oven_reg <= `DTFWX_BYTE_RST;
			fdc_reg <= `DTFWX_FDC_RST;
			dtls_reg <= `DTFWX_BYTE_RST;
			high_side_dead_time_reg <= `DTFWX_BYTE_RST;
			lsbuf_reg <= `DTFWX_BYTE_RST;
			hsbuf_reg <= `DTFWX_BYTE_RST;
			lsv_reg <= 1'b0;
			hsv_reg <= 1'b0;
			dir_reg <= `DTFWX_BYTE_RST;
			out_reg <= `DTFWX_BYTE_RST;
			err_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			oven_reg <= oven_next;
			fdc_reg <= fdc_next;
			dtls_reg <= dtls_next;
			high_side_dead_time_reg <= high_side_dead_time_next;
			lsbuf_reg <= lsbuf_next;
			hsbuf_reg <= hsbuf_next;
			lsv_reg <= lsv_next;
			hsv_reg <= hsv_next;
			dir_reg <= dir_next;
			out_reg <= out_next;
			err_reg <= err_next;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe = dir_reg;
	// Only enabled pairs are claimed (overridden pins in pattern mode), so the second timer keeps the rest
	assign pin_taken = pattern_mode ? oven_reg : (feature_on ? pair_mask : `DTFWX_BYTE_RST);
	assign override_enable_register = oven_reg;
	assign fault_detect_flag = f_flag;
	assign timer_error_pulse = err_reg;
	assign low_buf_valid = lsv_reg;
	assign high_buf_valid = hsv_reg;

	// ****************************************
	// Checks
	// ****************************************
	property p_lock;
		@(posedge sys_clk) disable iff (!rstn)
		ext_lock |=> (ctrl_reg == $past(ctrl_reg) && mask_reg == $past(mask_reg));
	endproperty
	a_lock: assert property (p_lock) else $error("locked register changed");

	property p_clroe;
		@(posedge sys_clk) disable iff (!rstn)
		(f_enter && act == `DTFWX_ACT_CLROE) |=> (oven_reg == 8'h00);
	endproperty
	a_clroe: assert property (p_clroe) else $error("override not cleared");

	property p_clrdir;
		@(posedge sys_clk) disable iff (!rstn)
		(f_enter && act == `DTFWX_ACT_CLRDIR && !pattern_mode) |=> ((pin_oe & $past(pair_mask)) == 8'h00);
	endproperty
	a_clrdir: assert property (p_clrdir) else $error("directions not cleared");

	property p_upd_only;
		@(posedge sys_clk) disable iff (!rstn)
		!upd |=> (dtls_reg == $past(dtls_reg));
	endproperty
	a_upd_only: assert property (p_upd_only) else $error("active value changed without update");

	property p_err;
		@(posedge sys_clk) disable iff (!rstn)
		f_enter |=> timer_error_pulse ##1 !timer_error_pulse;
	endproperty
	a_err: assert property (p_err) else $error("error pulse missing");

	property p_oe_reload;
		@(posedge sys_clk) disable iff (!rstn)
		(f_leave && act == `DTFWX_ACT_CLROE && !pattern_mode) |=> (oven_reg == $past(pair_mask));
	endproperty
	a_oe_reload: assert property (p_oe_reload) else $error("override not reloaded");

	property p_dir_restore;
		@(posedge sys_clk) disable iff (!rstn)
		(f_leave && act == `DTFWX_ACT_CLRDIR && !pattern_mode) |=> ((pin_oe & $past(pair_mask)) == $past(pair_mask));
	endproperty
	a_dir_restore: assert property (p_dir_restore) else $error("directions not restored");

	property p_pattern_a;
		@(posedge sys_clk) disable iff (!rstn)
		(pattern_mode && oven_reg[0]) |=> (pin_out[0] == $past(timer_waveform[0]));
	endproperty
	a_pattern_a: assert property (p_pattern_a) else $error("pattern pin not following channel A");
endmodule : dtfwx_top

// ===== design/dtfwx_defs.svh
/*
 * Constants for the dead-time and fault waveform extension.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DTFWX_DEFS_SVH
`define DTFWX_DEFS_SVH

`define DTFWX_NCH 4
`define DTFWX_NPIN 8
`define DTFWX_DTW 8
`define DTFWX_EVW 8
`define DTFWX_ACT_NONE 2'b00
`define DTFWX_ACT_CLROE 2'b01
`define DTFWX_ACT_CLRDIR 2'b11
`define DTFWX_CTRL_RST 6'h00
`define DTFWX_FDC_RST 5'h00
`define DTFWX_BYTE_RST 8'h00
`define DTFWX_CNT_ZERO 8'h00
`define DTFWX_CNT_ONE 8'h01

`endif

// ===== design/dtfwx_pkg.sv
/*
 * Types for the dead-time and fault waveform extension.
 * Assumes dtfwx_defs.svh is on the include path.
 */
package dtfwx_pkg;
`include "dtfwx_defs.svh"

	// Fault state machine, Gray coded along normal -> fault -> wait
	typedef enum logic [1:0] {
		DTFWX_RUN = 2'b00,
		DTFWX_FAULT = 2'b01,
		DTFWX_RESTORE = 2'b11
	} dtfwx_fstate_t;

	typedef logic [`DTFWX_DTW-1:0] dtfwx_byte_t;
	typedef logic [1:0] dtfwx_act_t;
endpackage : dtfwx_pkg

// ===== design/dtfwx_dtgen.sv
/*
 * One dead-time generator: counter plus complementary low/high outputs.
 * Assumes waveform input synchronous to sys_clk.
 */
module dtfwx_dtgen (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wave,
	input wire dtfwx_pkg::dtfwx_byte_t dt_low,
	input wire dtfwx_pkg::dtfwx_byte_t dt_high,
	output logic low_side_output,
	output logic high_side_output
);
	import dtfwx_pkg::*;
`include "dtfwx_defs.svh"

	logic wave_reg, wave_next;
	dtfwx_byte_t cnt_reg, cnt_next;
	logic ls_reg, ls_next, hs_reg, hs_next;

	always_comb begin
		wave_next = wave;
		cnt_next = cnt_reg;
		if (wave && !wave_reg) begin
			cnt_next = dt_low;
		end else if (!wave && wave_reg) begin
			cnt_next = dt_high;
		end else if (cnt_reg != `DTFWX_CNT_ZERO) begin
			cnt_next = cnt_reg - `DTFWX_CNT_ONE;
		end
		// Both off while counting
		ls_next = (cnt_next == `DTFWX_CNT_ZERO) && wave;
		hs_next = (cnt_next == `DTFWX_CNT_ZERO) && !wave;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wave_reg <= 1'b0;
			cnt_reg <= `DTFWX_CNT_ZERO;
			ls_reg <= 1'b0;
			hs_reg <= 1'b0;
		end else begin
			wave_reg <= wave_next;
			cnt_reg <= cnt_next;
			ls_reg <= ls_next;
			hs_reg <= hs_next;
		end
	end

	assign low_side_output = ls_reg;
	assign high_side_output = hs_reg;

	property p_dt_off;
		@(posedge sys_clk) disable iff (!rstn)
		(cnt_reg != `DTFWX_CNT_ZERO) |-> (!ls_reg && !hs_reg);
	endproperty
	a_dt_off: assert property (p_dt_off) else $error("output on during dead time");

	property p_dt_never_both;
		@(posedge sys_clk) disable iff (!rstn)
		!(ls_reg && hs_reg);
	endproperty
	a_dt_never_both: assert property (p_dt_never_both) else $error("both sides on");

	property p_dt_reload;
		@(posedge sys_clk) disable iff (!rstn)
		(wave && !wave_reg) |=> (cnt_reg == $past(dt_low));
	endproperty
	a_dt_reload: assert property (p_dt_reload) else $error("rise did not load low value");

	property p_dt_dec;
		@(posedge sys_clk) disable iff (!rstn)
		(wave == wave_reg && cnt_reg != `DTFWX_CNT_ZERO) |=> (cnt_reg == $past(cnt_reg) - `DTFWX_CNT_ONE);
	endproperty
	a_dt_dec: assert property (p_dt_dec) else $error("counter did not decrement");
endmodule : dtfwx_dtgen

// ===== design/dtfwx_fault.sv
/*
 * Fault detection, flag and restore state machine.
 * Assumes events and break request synchronous to sys_clk.
 */
module dtfwx_fault (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire dtfwx_pkg::dtfwx_byte_t fault_events,
	input wire dtfwx_pkg::dtfwx_byte_t event_mask,
	input wire logic debug_break,
	input wire logic break_fault_disable,
	input wire dtfwx_pkg::dtfwx_act_t fault_action_field,
	input wire logic cycle_mode,
	input wire logic flag_clear_write,
	input wire logic update,
	output logic fault_detect_flag,
	output logic fault_state,
	output logic fault_enter,
	output logic fault_leave
);
	import dtfwx_pkg::*;
`include "dtfwx_defs.svh"

	logic cond;
	logic flag_reg, flag_next;
	dtfwx_fstate_t st_reg, st_next;

	always_comb begin
		// Selected event channels ORed; break counts unless disabled
		cond = (fault_action_field != `DTFWX_ACT_NONE) &&
			((|(fault_events & event_mask)) || (debug_break && !break_fault_disable));
		// Set wins over the flag-clear write strobe
		flag_next = cond || (flag_reg && !flag_clear_write);
		st_next = st_reg;
		fault_enter = 1'b0;
		fault_leave = 1'b0;
		case (st_reg)
			DTFWX_RUN: begin
				if (cond) begin
					st_next = DTFWX_FAULT;
					fault_enter = 1'b1;
				end
			end
			DTFWX_FAULT: begin
				if (!cond && (cycle_mode || !flag_reg)) begin
					st_next = DTFWX_RESTORE;
				end
			end
			DTFWX_RESTORE: begin
				if (cond) begin
					st_next = DTFWX_FAULT;
					fault_enter = 1'b1;
				end else if (update) begin
					st_next = DTFWX_RUN;
					fault_leave = 1'b1;
				end
			end
			default: begin
				st_next = DTFWX_FAULT;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flag_reg <= 1'b0;
			st_reg <= DTFWX_RUN;
		end else begin
			flag_reg <= flag_next;
			st_reg <= st_next;
		end
	end

	assign fault_detect_flag = flag_reg;
	assign fault_state = (st_reg != DTFWX_RUN);

	property p_leave_on_update;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(fault_state) |-> $past(update);
	endproperty
	a_leave_on_update: assert property (p_leave_on_update) else $error("left fault without update");

	property p_latched_hold;
		@(posedge sys_clk) disable iff (!rstn)
		(st_reg == DTFWX_FAULT && !cycle_mode && flag_reg) |=> (st_reg == DTFWX_FAULT);
	endproperty
	a_latched_hold: assert property (p_latched_hold) else $error("latched fault released with flag set");

	property p_flag_set;
		@(posedge sys_clk) disable iff (!rstn)
		cond |=> fault_detect_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("fault flag not set");
endmodule : dtfwx_fault

// ===== testbench/dtfwx_timer_model.sv
/*
 * Timer/counter stand-in: channel waveforms and the UPDATE strobe.
 * Assumes the bench drives run, upd_req and cmp just after sys_clk rises.
 */
module dtfwx_timer_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic upd_req,
	input wire logic [31:0] cmp,
	output logic [3:0] timer_waveform,
	output logic timer_update
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PERIOD = 8'h10;
	logic [7:0] cnt_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 8'h00;
			timer_update <= 1'b0;
		end else begin
			cnt_reg <= (run && cnt_reg != PERIOD - 8'h01) ? cnt_reg + 8'h01 : 8'h00;
			// Wrap or forced strobe gives one UPDATE cycle
			timer_update <= upd_req | (run && cnt_reg == PERIOD - 8'h01);
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			timer_waveform[i] = cnt_reg < cmp[8*i +: 8];
		end
	end
endmodule : dtfwx_timer_model

// ===== testbench/dtfwx_top_tb.sv
/*
 * Self-checking bench for the dead-time and fault waveform extension.
 * Assumes dtfwx_timer_model drives the waveforms and update strobe.
 */
module dtfwx_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rstn = 1'b0, run = 1'b0, upd_req = 1'b0, lock_update = 1'b0;
	logic debug_break = 1'b0, ext_lock = 1'b0, ctrl_write = 1'b0, mask_write = 1'b0, fdctrl_write = 1'b0;
	logic flag_clear_write = 1'b0, oven_write = 1'b0, dtls_buf_write = 1'b0, high_side_dead_time_buf_write = 1'b0;
	logic [5:0] ctrl_wdata = 6'h00;
	logic [4:0] fdctrl_wdata = 5'h00;
	logic [7:0] port_value = 8'h00, port_direction_in = 8'hff, fault_events = 8'h00, mask_wdata = 8'h00;
	logic [7:0] oven_wdata = 8'h00, dt_buf_wdata = 8'h00, err_cnt = 8'h00, r;
	logic [31:0] cmp = 32'h0;
	logic [3:0] timer_waveform;
	logic timer_update, fault_detect_flag, timer_error_pulse, low_buf_valid, high_buf_valid;
	logic [7:0] pin_out, pin_oe, pin_taken, ovr;
	int n_fail = 0, check_count = 0, s;
	int sel_q[$];
	logic [7:0] exp_q[$];
	event chk_ev;
	string nm[8] = '{"pin_out", "pin_oe", "pin_taken", "override", "flag", "buf_valid", "err_pulses", "free_pins"};

	always #5 sys_clk = ~sys_clk;

	dtfwx_timer_model timer (.sys_clk(sys_clk), .rstn(rstn), .run(run), .upd_req(upd_req), .cmp(cmp),
		.timer_waveform(timer_waveform), .timer_update(timer_update));

	dtfwx_top DUT (.sys_clk(sys_clk), .rstn(rstn), .timer_waveform(timer_waveform), .timer_update(timer_update),
		.lock_update(lock_update), .port_value(port_value), .port_direction_in(port_direction_in),
		.fault_events(fault_events), .debug_break(debug_break), .ext_lock(ext_lock), .ctrl_write(ctrl_write),
		.ctrl_wdata(ctrl_wdata), .mask_write(mask_write), .mask_wdata(mask_wdata), .fdctrl_write(fdctrl_write),
		.fdctrl_wdata(fdctrl_wdata), .flag_clear_write(flag_clear_write), .oven_write(oven_write),
		.oven_wdata(oven_wdata), .dtls_buf_write(dtls_buf_write), .high_side_dead_time_buf_write(high_side_dead_time_buf_write),
		.dt_buf_wdata(dt_buf_wdata), .pin_out(pin_out), .pin_oe(pin_oe), .pin_taken(pin_taken),
		.override_enable_register(ovr), .fault_detect_flag(fault_detect_flag),
		.timer_error_pulse(timer_error_pulse), .low_buf_valid(low_buf_valid), .high_buf_valid(high_buf_valid));

	/***************************************************************
	 * Helpers
	 ***************************************************************/
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	// k: 0 ctrl, 1 mask, 2 fault ctrl, 3 flag clear, 4 override, 5 low buf, 6 high buf, 7 both bufs
	task wr(input int k, input logic [7:0] d);
		ctrl_wdata = d[5:0];
		mask_wdata = d;
		fdctrl_wdata = d[4:0];
		oven_wdata = d;
		dt_buf_wdata = d;
		{high_side_dead_time_buf_write, dtls_buf_write, oven_write, flag_clear_write, fdctrl_write, mask_write, ctrl_write} =
			(k == 7) ? 7'h60 : 7'h01 << k;
		step(1);
		{high_side_dead_time_buf_write, dtls_buf_write, oven_write, flag_clear_write, fdctrl_write, mask_write, ctrl_write} = 7'h00;
		step(1);
	endtask : wr

	task upd();
		upd_req = 1'b1;
		step(1);
		upd_req = 1'b0;
		step(3);
	endtask : upd

	task note(input int sel, input logic [7:0] e);
		sel_q.push_back(sel);
		exp_q.push_back(e);
		->chk_ev;
	endtask : note

	function logic [7:0] seen_of(input int sel);
		case (sel)
			0: return pin_out;
			1: return pin_oe;
			2: return pin_taken;
			3: return ovr;
			4: return {7'h00, fault_detect_flag};
			5: return {6'h00, high_buf_valid, low_buf_valid};
			6: return err_cnt;
			default: return pin_out & 8'h30;
		endcase
	endfunction : seen_of

	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	always @(chk_ev) begin
		while (sel_q.size() > 0) begin
			s = sel_q.pop_front();
			check(nm[s], seen_of(s), exp_q.pop_front());
		end
	end

	always @(posedge sys_clk) begin
		if (timer_error_pulse === 1'b1) err_cnt <= err_cnt + 8'h01;
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		results();
	end

	/***************************************************************
	 * Tests
	 ***************************************************************/
	initial begin
		void'($urandom(74516));
		step(20);
		rstn = 1'b1;
		step(1);
		wr(0, 8'h01);
		note(2, 8'h03);
		wr(4, 8'h03);
		wr(7, 8'h02);
		wr(6, 8'h09);
		note(5, 8'h03);
		lock_update = 1'b1;
		upd();
		note(5, 8'h03);
		lock_update = 1'b0;
		upd();
		note(5, 8'h00);
		step(12);
		note(0, 8'h02);
		cmp[7:0] = 8'h01;
		step(2);
		note(0, 8'h00);
		step(5);
		note(0, 8'h01);
		cmp[7:0] = 8'h00;
		step(6);
		note(0, 8'h00);
		step(8);
		note(0, 8'h02);
		$display("test dead_time done");
		wr(1, 8'h04);
		wr(2, 8'h01);
		fault_events = 8'h01;
		step(2);
		fault_events = 8'h00;
		note(4, 8'h00);
		fault_events = 8'h04;
		step(2);
		fault_events = 8'h00;
		note(4, 8'h01);
		note(3, 8'h00);
		step(2);
		note(6, 8'h01);
		wr(4, 8'hff);
		upd();
		note(3, 8'h00);
		wr(3, 8'h01);
		note(4, 8'h00);
		upd();
		note(3, 8'h03);
		$display("test clear_override done");
		wr(2, 8'h07);
		fault_events = 8'h04;
		step(2);
		note(1, 8'hfc);
		upd();
		note(1, 8'hfc);
		fault_events = 8'h00;
		run = 1'b1;
		step(40);
		run = 1'b0;
		note(1, 8'hff);
		wr(3, 8'h01);
		$display("test clear_direction done");
		for (int a = 0; a < 2; a++) begin
			wr(2, a ? 8'h02 : 8'h00);
			fault_events = 8'h04;
			step(2);
			fault_events = 8'h00;
			note(3, 8'h03);
			note(1, 8'hff);
			wr(3, 8'h01);
			upd();
		end
		$display("test no_action done");
		wr(2, 8'h01);
		debug_break = 1'b1;
		step(2);
		note(3, 8'h00);
		debug_break = 1'b0;
		wr(3, 8'h01);
		upd();
		note(3, 8'h03);
		wr(2, 8'h11);
		debug_break = 1'b1;
		step(2);
		note(4, 8'h00);
		debug_break = 1'b0;
		$display("test debug_break done");
		r = 8'($urandom);
		port_value = r;
		wr(0, 8'h0b);
		note(2, 8'hcf);
		note(7, r & 8'h30);
		ext_lock = 1'b1;
		wr(0, 8'h01);
		wr(4, 8'hff);
		wr(1, 8'h01);
		wr(2, 8'h01);
		fault_events = 8'h01;
		step(2);
		fault_events = 8'h00;
		note(2, 8'hcf);
		note(3, 8'h03);
		note(4, 8'h00);
		ext_lock = 1'b0;
		$display("test lock done");
		wr(0, 8'h20);
		port_value = 8'h02;
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom);
			wr(4, r);
			cmp[7:0] = {7'h00, i[0]};
			step(3);
			note(0, (r & {8{i[0]}}) | (~r & 8'h02));
		end
		$display("test pattern done");
		step(2);
		results();
	end
endmodule : dtfwx_top_tb
